// ---- common/afc_pkg.sv ----
// Constants and carrier types for the host controller of a 1024 x 9 strobed FIFO device
package afc_pkg;
    // ==================================================================
    // Geometry
    localparam int WORD_W = 9;
    localparam int DEV_DEPTH = 1024;
    localparam int CNT_W = 11;
    localparam int BUF_DEPTH = 32;

    // ==================================================================
    // Timing, in ns, and derived clock counts at 40 MHz
    localparam int CLK_NS = 25;
    localparam int RST_LOW_NS = 100;
    localparam int RST_REC_NS = 50;
    localparam int WR_LOW_NS = 50;
    localparam int RD_LOW_NS = 100;
    localparam int RT_LOW_NS = 50;
    localparam int RECOVER_NS = 75;
    localparam int TCNT_W = 4;
    localparam logic [TCNT_W-1:0] RST_LOW_CYC = TCNT_W'((RST_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TCNT_W-1:0] RST_REC_CYC = TCNT_W'((RST_REC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TCNT_W-1:0] WR_LOW_CYC = TCNT_W'((WR_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TCNT_W-1:0] RD_LOW_CYC = TCNT_W'((RD_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TCNT_W-1:0] RT_LOW_CYC = TCNT_W'((RT_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TCNT_W-1:0] RECOVER_CYC = TCNT_W'((RECOVER_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] DEV_FULL_CNT = CNT_W'(DEV_DEPTH);

    // ==================================================================
    // Types
    typedef enum {
        AFC_RST_LOW, AFC_RST_REC, AFC_IDLE, AFC_WR_LOW, AFC_RD_LOW, AFC_RT_LOW, AFC_RECOVER
    } afc_state_t;

    // Status flags as seen on the device pins, all active low
    typedef struct packed {
        logic empty_n;
        logic half_n;
        logic full_n;
    } afc_flags_t;

    // Device reset state: empty asserted, half-full and full released
    localparam afc_flags_t FLAGS_RST = 3'h3;
endpackage

// ---- src/afc_host.sv ----
// Host controller that drives a strobed 1024 x 9 FIFO device, with its write-side buffer
`timescale 1ns/1ps
`default_nettype none

// ======================================================================
// Word buffer with valid/ready on both sides
module afc_buf #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic next_in_ready;
    logic push, pop;

    always_comb begin
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
        next_count = (AW+1)'(count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
        next_in_ready = next_count != (AW+1)'(DEPTH);
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready_o <= 1'b1;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            in_ready_o <= next_in_ready;
        end
    end

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    assign out_valid_o = count != '0;
    assign out_data_o = mem[rd_ptr];
endmodule // afc_buf

// ======================================================================
// Rules from the document, for the device and for this host
// R1: Device holds 1024 nine-bit words, internally addressed; host sends no address.
// R2: Device returns words in the order written; host reads them out in turn.
// R3: Low reset zeroes both device pointers and discards stored data.
// R4: Reset makes empty flag low, half-full and full high, outputs floating.
// R5: Device samples expansion-in and first-load/rewind during reset to pick mode.
// R6: Host returns both strobes high before the reset rising edge.
// R7: Write starts on write strobe fall; host writes only while full flag high.
// R8: Half-full flag falls on the first write past half capacity.
// R9: Half-full flag rises on the read that leaves at most half stored.
// R10: Full flag falls on the write filling the last location; writes blocked.
// R11: Full flag rises after the next read frees a location.
// R12: Read strobe fall presents next word; outputs float after strobe rises.
// R13: Host reads only while empty flag high; reads independent of writes.
// R14: Empty flag falls after the last word is read, rises after next write.
// R15: Read held low while empty flows the next written word through once.
// R16: Write held low while full stores its word after the next read.
// R17: Rewind sets read pointer to zero, keeps write pointer, allows rereading.
// R18: Host keeps pointers from wrapping past zero during a rewind sequence.
// R19: Cascade mode uses first-load select; half-full and rewind then unavailable.
// R20: Flags follow unread count: 0, 1-512, 513-1023, 1024.
// R21: Host holds both strobes high throughout the low rewind pulse.
// R22: Device derives its flags from write pointer minus read pointer.
module afc_host (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // User commands and mode
    input wire logic dev_reset_req_i,
    input wire logic rewind_req_i,
    input wire logic cascade_mode_i,
    input wire logic first_load_i,
    // User write stream
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    input wire logic [afc_pkg::WORD_W-1:0] wr_data_i,
    // User read stream
    input wire logic rd_req_i,
    output logic rd_valid_o,
    output logic [afc_pkg::WORD_W-1:0] rd_data_o,
    // User status
    output logic busy_o,
    output logic dev_empty_o,
    output logic dev_half_o,
    output logic dev_full_o,
    output logic wrap_guard_o,
    // Device pins
    output logic reset_n_o,
    output logic write_strobe_n_o,
    output logic read_strobe_n_o,
    output logic first_load_or_rewind_n_o,
    output logic expansion_in_n_o,
    output logic [afc_pkg::WORD_W-1:0] write_data_bus_o,
    input wire logic [afc_pkg::WORD_W-1:0] read_data_bus_i,
    input wire logic empty_flag_n_i,
    input wire logic full_flag_n_i,
    input wire logic expansion_out_or_half_full_n_i
);
    // ==================================================================
    // Pin synchronisers
    afc_pkg::afc_flags_t flag_meta, flag_sync, flag_raw;
    logic [afc_pkg::WORD_W-1:0] rd_meta, rd_sync;

    assign flag_raw = '{empty_n: empty_flag_n_i, half_n: expansion_out_or_half_full_n_i, full_n: full_flag_n_i};

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flag_meta <= afc_pkg::FLAGS_RST;
            flag_sync <= afc_pkg::FLAGS_RST;
            rd_meta <= '0;
            rd_sync <= '0;
        end else begin
            flag_meta <= flag_raw;
            flag_sync <= flag_meta;
            rd_meta <= read_data_bus_i;
            rd_sync <= rd_meta;
        end
    end

    // ==================================================================
    // Write buffer
    logic buf_valid, buf_pop;
    logic [afc_pkg::WORD_W-1:0] buf_data;

    afc_buf #(.WIDTH(afc_pkg::WORD_W), .DEPTH(afc_pkg::BUF_DEPTH)) u_buf (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(wr_valid_i),
        .in_ready_o(wr_ready_o),
        .in_data_i(wr_data_i),
        .out_valid_o(buf_valid),
        .out_ready_i(buf_pop),
        .out_data_o(buf_data)
    );

    // ==================================================================
    // Sequencer
    afc_pkg::afc_state_t state, next_state;
    logic [afc_pkg::TCNT_W-1:0] tcnt, next_tcnt;
    logic cascade, next_cascade, first_load, next_first_load;
    logic rewound, next_rewound;
    logic [afc_pkg::CNT_W-1:0] wr_total, next_wr_total;
    logic next_reset_n, next_wr_n, next_rd_n, next_rt_n, next_rd_valid, next_busy;
    logic [afc_pkg::WORD_W-1:0] next_wdata, next_rdata;
    logic wrap_block, can_write, can_read;

    always_comb begin
        // Once rewound, the device write pointer must not pass zero again
        wrap_block = rewound && (wr_total == afc_pkg::DEV_FULL_CNT); // R18
        can_write = buf_valid && flag_sync.full_n && !wrap_block; // R7
        can_read = rd_req_i && flag_sync.empty_n; // R13
        next_state = state;
        next_tcnt = (tcnt != '0) ? afc_pkg::TCNT_W'(tcnt - 1'b1) : tcnt;
        next_cascade = cascade;
        next_first_load = first_load;
        next_rewound = rewound;
        next_wr_total = wr_total;
        next_reset_n = reset_n_o;
        next_wr_n = write_strobe_n_o;
        next_rd_n = read_strobe_n_o;
        next_rt_n = 1'b1;
        next_wdata = write_data_bus_o;
        next_rdata = rd_data_o;
        next_rd_valid = 1'b0;
        buf_pop = 1'b0;
        case (state)
            afc_pkg::AFC_RST_LOW: begin
                // Strobes go high at once so they are settled well before reset rises
                next_wr_n = 1'b1; // R6
                next_rd_n = 1'b1; // R6
                if (tcnt == '0) begin
                    next_reset_n = 1'b1;
                    next_tcnt = afc_pkg::RST_REC_CYC;
                    next_state = afc_pkg::AFC_RST_REC;
                end
            end
            afc_pkg::AFC_RST_REC: begin
                if (tcnt == '0) begin
                    next_state = afc_pkg::AFC_IDLE;
                end
            end
            afc_pkg::AFC_IDLE: begin
                if (dev_reset_req_i) begin
                    next_cascade = cascade_mode_i;
                    next_first_load = first_load_i;
                    next_reset_n = 1'b0;
                    next_rewound = 1'b0;
                    next_wr_total = '0;
                    next_tcnt = afc_pkg::RST_LOW_CYC;
                    next_state = afc_pkg::AFC_RST_LOW;
                end else if (rewind_req_i && !cascade) begin // R19
                    next_rt_n = 1'b0; // R17
                    next_rewound = 1'b1;
                    next_tcnt = afc_pkg::TCNT_W'(afc_pkg::RT_LOW_CYC - 1'b1);
                    next_state = afc_pkg::AFC_RT_LOW;
                end else if (can_write) begin
                    buf_pop = 1'b1;
                    next_wdata = buf_data;
                    next_wr_n = 1'b0; // R7
                    if (wr_total != afc_pkg::DEV_FULL_CNT) begin
                        next_wr_total = afc_pkg::CNT_W'(wr_total + 1'b1);
                    end
                    next_tcnt = afc_pkg::TCNT_W'(afc_pkg::WR_LOW_CYC - 1'b1);
                    next_state = afc_pkg::AFC_WR_LOW;
                end else if (can_read) begin
                    next_rd_n = 1'b0; // R13
                    next_tcnt = afc_pkg::TCNT_W'(afc_pkg::RD_LOW_CYC - 1'b1);
                    next_state = afc_pkg::AFC_RD_LOW;
                end
            end
            afc_pkg::AFC_WR_LOW: begin
                if (tcnt == '0) begin
                    next_wr_n = 1'b1;
                    next_tcnt = afc_pkg::RECOVER_CYC;
                    next_state = afc_pkg::AFC_RECOVER;
                end
            end
            afc_pkg::AFC_RD_LOW: begin
                // Captured late so the access time and the synchroniser delay are covered
                if (tcnt == '0) begin
                    next_rdata = rd_sync; // R2
                    next_rd_valid = 1'b1;
                    next_rd_n = 1'b1;
                    next_tcnt = afc_pkg::RECOVER_CYC;
                    next_state = afc_pkg::AFC_RECOVER;
                end
            end
            afc_pkg::AFC_RT_LOW: begin
                next_rt_n = 1'b0; // R21
                if (tcnt == '0) begin
                    next_rt_n = 1'b1;
                    next_tcnt = afc_pkg::RECOVER_CYC;
                    next_state = afc_pkg::AFC_RECOVER;
                end
            end
            afc_pkg::AFC_RECOVER: begin
                // Wait for flags to settle through the synchroniser before deciding again
                if (tcnt == '0) begin
                    next_state = afc_pkg::AFC_IDLE;
                end
            end
            default: begin
                next_state = afc_pkg::AFC_IDLE;
            end
        endcase
        next_busy = next_state != afc_pkg::AFC_IDLE;
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= afc_pkg::AFC_RST_LOW;
            tcnt <= afc_pkg::RST_LOW_CYC;
            cascade <= 1'b0;
            first_load <= 1'b0;
            rewound <= 1'b0;
            wr_total <= '0;
            reset_n_o <= 1'b0;
            write_strobe_n_o <= 1'b1;
            read_strobe_n_o <= 1'b1;
            first_load_or_rewind_n_o <= 1'b1;
            expansion_in_n_o <= 1'b0;
            write_data_bus_o <= '0;
            rd_data_o <= '0;
            rd_valid_o <= 1'b0;
            busy_o <= 1'b1;
            dev_empty_o <= 1'b1;
            dev_half_o <= 1'b0;
            dev_full_o <= 1'b0;
            wrap_guard_o <= 1'b0;
        end else begin
            state <= next_state;
            tcnt <= next_tcnt;
            cascade <= next_cascade;
            first_load <= next_first_load;
            rewound <= next_rewound;
            wr_total <= next_wr_total;
            reset_n_o <= next_reset_n;
            write_strobe_n_o <= next_wr_n;
            read_strobe_n_o <= next_rd_n;
            // Mode straps: low expansion-in selects standalone, first-load pin picks master
            first_load_or_rewind_n_o <= next_cascade ? !next_first_load : next_rt_n; // R19
            expansion_in_n_o <= next_cascade; // R19
            write_data_bus_o <= next_wdata;
            rd_data_o <= next_rdata;
            rd_valid_o <= next_rd_valid;
            busy_o <= next_busy;
            dev_empty_o <= !flag_sync.empty_n;
            // Half-full pin is expansion-out in cascade mode, so it is not reported
            dev_half_o <= !cascade && !flag_sync.half_n;
            dev_full_o <= !flag_sync.full_n;
            wrap_guard_o <= wrap_block;
        end
    end

    // ==================================================================
    // Checks
    AST_RESET_STROBES_HIGH: assert property (@(posedge clock_i) disable iff (sys_rst_i) // R6
        $rose(reset_n_o) |-> $past(write_strobe_n_o) && $past(read_strobe_n_o))
        else $error("strobe low when device reset released");
    AST_WRITE_WHEN_NOT_FULL: assert property (@(posedge clock_i) disable iff (sys_rst_i) // R7
        $fell(write_strobe_n_o) |-> $past(flag_sync.full_n) && reset_n_o)
        else $error("write started while device full");
    AST_WRITE_WIDTH: assert property (@(posedge clock_i) disable iff (sys_rst_i) // R7
        $fell(write_strobe_n_o) |-> ##1 !write_strobe_n_o ##1 write_strobe_n_o)
        else $error("write strobe width wrong");
    AST_READ_WHEN_NOT_EMPTY: assert property (@(posedge clock_i) disable iff (sys_rst_i) // R13
        $fell(read_strobe_n_o) |-> $past(flag_sync.empty_n))
        else $error("read started while device empty");
    AST_READ_DELIVERS: assert property (@(posedge clock_i) disable iff (sys_rst_i) // R13
        $fell(read_strobe_n_o) |-> ##4 rd_valid_o && $rose(read_strobe_n_o))
        else $error("read word not delivered on time");
    AST_NO_WRAP: assert property (@(posedge clock_i) disable iff (sys_rst_i) // R18
        $fell(write_strobe_n_o) |-> !$past(wrap_block))
        else $error("write would wrap after rewind");
    AST_REWIND_STROBES_HIGH: assert property (@(posedge clock_i) disable iff (sys_rst_i) // R21
        (!cascade && !first_load_or_rewind_n_o) |-> write_strobe_n_o && read_strobe_n_o)
        else $error("strobe low during rewind pulse");
    AST_REWIND_WIDTH: assert property (@(posedge clock_i) disable iff (sys_rst_i) // R21
        (!cascade && $fell(first_load_or_rewind_n_o)) |-> ##1 !first_load_or_rewind_n_o ##1 first_load_or_rewind_n_o)
        else $error("rewind pulse width wrong");
    AST_CASCADE_NO_REWIND: assert property (@(posedge clock_i) disable iff (sys_rst_i) // R19
        (cascade && reset_n_o) |-> $stable(first_load_or_rewind_n_o))
        else $error("first-load pin moved in cascade mode");
endmodule // afc_host

`default_nettype wire

// ---- verification/afc_dev_model.sv ----
// Behavioural model of the strobed 1024 x 9 FIFO device on the far side of the host controller
`timescale 1ns/1ps
`default_nettype none
module afc_dev_model (
    // Control pins
    input wire logic reset_n,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic first_load_or_rewind_n,
    input wire logic expansion_in_n,
    // Data and status pins
    input wire logic [afc_pkg::WORD_W-1:0] write_data_bus,
    output logic [afc_pkg::WORD_W-1:0] read_data_bus,
    output logic empty_flag_n,
    output logic full_flag_n,
    output logic expansion_out_or_half_full_n
);
    // ==================================================================
    // Storage, pointers and mode
    logic [afc_pkg::WORD_W-1:0] mem [afc_pkg::DEV_DEPTH];
    logic [afc_pkg::WORD_W-1:0] q_val = '0;
    logic cascaded = 1'b0;
    logic q_on = 1'b0;
    int wp = 0;
    int rp = 0;
    int wpend = 0;
    int rpend = 0;
    int cnt;
    int held;
    assign cnt = wp - rp;
    // Pending strobes count early so full and half move on the documented edges
    assign held = cnt + wpend + rpend;

    // ==================================================================
    // Reset, write, read and rewind
    always @(reset_n or expansion_in_n) begin
        if (!reset_n) begin
            wp = 0;
            rp = 0;
            wpend = 0;
            rpend = 0;
            q_on = 1'b0;
            cascaded = expansion_in_n;
        end
    end
    always @(negedge write_strobe_n) begin
        wpend = (reset_n && held < afc_pkg::DEV_DEPTH) ? 1 : 0;
    end
    always @(posedge write_strobe_n) begin
        if (wpend == 1) begin
            mem[wp % afc_pkg::DEV_DEPTH] = write_data_bus;
            wp++;
        end
        wpend = 0;
    end
    always @(negedge read_strobe_n) begin
        if (reset_n && cnt > 0) begin
            q_val = mem[rp % afc_pkg::DEV_DEPTH];
            rp++;
            rpend = 1;
            q_on = 1'b1;
        end
    end
    always @(posedge read_strobe_n) begin
        rpend = 0;
        q_on = 1'b0;
    end
    always @(negedge first_load_or_rewind_n) begin
        if (reset_n && !cascaded && read_strobe_n && write_strobe_n) rp = 0;
    end

    // ==================================================================
    // Pins; a released data bus shows the inverse of its last word
    assign read_data_bus = (q_on && !read_strobe_n) ? q_val : ~q_val;
    assign empty_flag_n = (cnt != 0);
    assign full_flag_n = (held < afc_pkg::DEV_DEPTH);
    assign expansion_out_or_half_full_n = cascaded || (held <= afc_pkg::DEV_DEPTH / 2);
endmodule // afc_dev_model
`default_nettype wire

// ---- verification/afc_host_tb.sv ----
// Self-checking bench for the strobed FIFO host controller against the device model
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin miscompares++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module afc_host_tb;
    // ==================================================================
    // Signals
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic dev_reset_req_i = 1'b0;
    logic rewind_req_i = 1'b0;
    logic cascade_mode_i = 1'b0;
    logic first_load_i = 1'b0;
    logic wr_valid_i = 1'b0;
    logic rd_req_i = 1'b0;
    logic [afc_pkg::WORD_W-1:0] wr_data_i = '0;
    logic wr_ready_o, rd_valid_o, busy_o, dev_empty_o, dev_half_o, dev_full_o, wrap_guard_o;
    logic [afc_pkg::WORD_W-1:0] rd_data_o, wbus, rbus, mon_exp, extra;
    logic rst_n, wstb_n, rstb_n, flrt_n, xin_n, ef_n, ff_n, hf_n;
    logic [afc_pkg::WORD_W-1:0] exp_q[$], saved_q[$];
    int miscompares = 0;
    int num_checks = 0;

    always #12.5 clock_i = ~clock_i;

    afc_host afc_host_i (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .dev_reset_req_i(dev_reset_req_i), .rewind_req_i(rewind_req_i),
        .cascade_mode_i(cascade_mode_i), .first_load_i(first_load_i), .wr_valid_i(wr_valid_i),
        .wr_ready_o(wr_ready_o), .wr_data_i(wr_data_i), .rd_req_i(rd_req_i), .rd_valid_o(rd_valid_o),
        .rd_data_o(rd_data_o), .busy_o(busy_o), .dev_empty_o(dev_empty_o), .dev_half_o(dev_half_o),
        .dev_full_o(dev_full_o), .wrap_guard_o(wrap_guard_o), .reset_n_o(rst_n), .write_strobe_n_o(wstb_n),
        .read_strobe_n_o(rstb_n), .first_load_or_rewind_n_o(flrt_n), .expansion_in_n_o(xin_n),
        .write_data_bus_o(wbus), .read_data_bus_i(rbus), .empty_flag_n_i(ef_n), .full_flag_n_i(ff_n),
        .expansion_out_or_half_full_n_i(hf_n));
    afc_dev_model afc_dev_model_i (
        .reset_n(rst_n), .write_strobe_n(wstb_n), .read_strobe_n(rstb_n), .first_load_or_rewind_n(flrt_n),
        .expansion_in_n(xin_n), .write_data_bus(wbus), .read_data_bus(rbus), .empty_flag_n(ef_n),
        .full_flag_n(ff_n), .expansion_out_or_half_full_n(hf_n));

    // ==================================================================
    // Tasks
    task automatic print_verdict;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wait_idle;
        int t = 0;
        repeat (2) @(negedge clock_i);
        while (busy_o !== 1'b0 && t < 200) begin
            @(negedge clock_i);
            t++;
        end
        `CHK("idle wait", 1'b0, busy_o)
    endtask
    task automatic pulse_req(input bit rew);
        @(negedge clock_i);
        if (rew) rewind_req_i = 1'b1;
        else dev_reset_req_i = 1'b1;
        @(negedge clock_i);
        rewind_req_i = 1'b0;
        dev_reset_req_i = 1'b0;
        wait_idle();
    endtask
    task automatic send(input logic [afc_pkg::WORD_W-1:0] d);
        int t = 0;
        @(negedge clock_i);
        wr_valid_i = 1'b1;
        wr_data_i = d;
        while (wr_ready_o !== 1'b1 && t < 20000) begin
            @(negedge clock_i);
            t++;
        end
        `CHK("buffer accept", 1'b1, wr_ready_o)
        exp_q.push_back(d);
        @(negedge clock_i);
        wr_valid_i = 1'b0;
    endtask
    task automatic drain;
        int t = 0;
        @(negedge clock_i);
        rd_req_i = 1'b1;
        while (exp_q.size() != 0 && t < 40000) begin
            @(negedge clock_i);
            t++;
        end
        // Keep asking while empty so any read past the last word is caught
        repeat (30) @(negedge clock_i);
        rd_req_i = 1'b0;
        wait_idle();
        `CHK("words left", 0, exp_q.size())
    endtask

    // ==================================================================
    // Read monitor
    always @(negedge clock_i) begin
        if (rd_valid_o === 1'b1) begin
            if (exp_q.size() == 0) `CHK("read while empty", 1'b0, 1'b1)
            else begin
                mon_exp = exp_q.pop_front();
                `CHK("read word", mon_exp, rd_data_o)
            end
        end
    end

    // ==================================================================
    // Watchdog and main sequence
    initial begin
        repeat (80000) @(posedge clock_i);
        $display("ERROR watchdog expired");
        miscompares++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'h8be5d11b));
        repeat (20) @(negedge clock_i);
        sys_rst_i = 1'b0;
        wait_idle();
        `CHK("empty after reset", 3'h4, {dev_empty_o, dev_half_o, dev_full_o})
        for (int i = 0; i < afc_pkg::DEV_DEPTH + afc_pkg::BUF_DEPTH; i++) begin
            send(afc_pkg::WORD_W'($urandom));
            if (i == 511 || i == 512) begin
                repeat (250) @(negedge clock_i);
                `CHK("half flag at boundary", i == 512, dev_half_o)
            end
        end
        repeat (250) @(negedge clock_i);
        `CHK("full device and buffer", 4'h6, {wr_ready_o, dev_full_o, dev_half_o, ff_n})
        drain();
        `CHK("flags after drain", 3'h4, {dev_empty_o, dev_half_o, dev_full_o})
        pulse_req(1'b0);
        for (int i = 0; i < 5; i++) send(afc_pkg::WORD_W'($urandom));
        saved_q = exp_q;
        drain();
        pulse_req(1'b1);
        `CHK("words back after rewind", 1'b0, dev_empty_o)
        exp_q = saved_q;
        drain();
        // 1025 words sent since reset after a rewind; the device takes 1024, so the last word sent must wait in the buffer
        for (int i = 5; i <= afc_pkg::DEV_DEPTH; i++) send(afc_pkg::WORD_W'($urandom));
        repeat (250) @(negedge clock_i);
        `CHK("wrap guard holds word", 3'h4, {wrap_guard_o, dev_full_o, dev_empty_o})
        extra = exp_q.pop_back();
        drain();
        // The held word reaches the device after the next device reset
        exp_q.push_back(extra);
        for (int fl = 0; fl < 2; fl++) begin
            cascade_mode_i = 1'b1;
            first_load_i = fl[0];
            pulse_req(1'b0);
            `CHK("cascade mode pins", {1'b1, ~fl[0]}, {xin_n, flrt_n})
            for (int i = 0; i < 3; i++) send(afc_pkg::WORD_W'($urandom));
            drain();
            pulse_req(1'b1);
            `CHK("no rewind in cascade", {2'h2, ~fl[0]}, {dev_empty_o, dev_half_o, flrt_n})
        end
        cascade_mode_i = 1'b0;
        pulse_req(1'b0);
        `CHK("standalone pins", 1'b0, xin_n)
        print_verdict();
    end
endmodule // afc_host_tb
`default_nettype wire
